// ==== inc/swdb_pkg.sv ====
// Package of constants for the switch input debounce and edge block.
`default_nettype none
package swdb_pkg;
    localparam int SWDB_NUM_INPUTS = 26;
    localparam int SWDB_NUM_HIGH_SIDE = 18;
    localparam int SWDB_NUM_LOW_SIDE = 4;
    localparam int SWDB_NUM_ENCODER = 4;
    localparam int SWDB_NUM_LATCHED = 24;
    localparam int SWDB_NUM_ENC_LATCHED = SWDB_NUM_INPUTS - SWDB_NUM_LATCHED;
    // Timing.
    localparam int SWDB_CLK_HZ = 100_000_000;
    localparam int SWDB_SAMPLE_HZ = 250;
    localparam int SWDB_SAMPLE_CYCLES = SWDB_CLK_HZ / SWDB_SAMPLE_HZ;
    localparam int SWDB_STEP_MS = 4;
    localparam int SWDB_SAMPLE_MS = 1000 / SWDB_SAMPLE_HZ;
    localparam int SWDB_TICKS_PER_STEP = SWDB_STEP_MS / SWDB_SAMPLE_MS;
    localparam int SWDB_STEP_W = 4;
    localparam logic [3:0] SWDB_STEP_MAX = 4'h8;
    localparam logic [3:0] SWDB_STEP_DEFAULT = 4'h4;
    localparam int SWDB_CNT_W = 4;
    // Register byte offsets.
    localparam logic [7:0] SWDB_OFS_STATE = 8'h00;
    localparam logic [7:0] SWDB_OFS_PRESS = 8'h04;
    localparam logic [7:0] SWDB_OFS_RELEASE = 8'h08;
    localparam logic [7:0] SWDB_OFS_PRESS_MASK = 8'h0C;
    localparam logic [7:0] SWDB_OFS_RELEASE_MASK = 8'h10;
    localparam logic [7:0] SWDB_OFS_DEBOUNCE = 8'h14;
    localparam logic [7:0] SWDB_OFS_RAW = 8'h18;
    localparam logic [31:0] SWDB_RESET_MASK = 32'h0000_0000;
    localparam logic [1:0] SWDB_HTRANS_NONSEQ = 2'b10;
endpackage
`default_nettype wire

// ==== rtl/swdb_tick.sv ====
// Sample-rate tick divider for the switch front end.
`default_nettype none
module swdb_tick #(
    parameter int DIVIDE = swdb_pkg::SWDB_SAMPLE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic tick
);
    import swdb_pkg::*;
    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } swdb_tick_s;
    swdb_tick_s st;
    swdb_tick_s next_st;

    // Free-running counter; one pulse per sample period.
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.count >= 32'(DIVIDE - 1)) begin
            next_st.count = 32'h0000_0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.count = st.count + 32'h0000_0001;
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule
`default_nettype wire

// ==== rtl/swdb_filter.sv ====
// Debounce filter for one switch input.
`default_nettype none
module swdb_filter #(
    parameter int CNT_W = swdb_pkg::SWDB_CNT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic sample,
    input wire logic [CNT_W-1:0] limit,
    output logic state
);
    import swdb_pkg::*;
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic state;
    } swdb_filter_s;
    swdb_filter_s st;
    swdb_filter_s next_st;

    // Count ticks while the sample disagrees; any agreement restarts the run.
    always_comb begin
        next_st = st;
        if (tick) begin
            if (sample == st.state) begin
                next_st.count = '0;
            end else if (limit == '0 || st.count + 1'b1 >= limit) begin // R16
                next_st.state = sample;
                next_st.count = '0;
            end else begin
                next_st.count = st.count + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign state = st.state;
endmodule
`default_nettype wire

// ==== rtl/swdb_top.sv ====
// Switch input front end: polarity, debounce, press and release latches, AHB-Lite slave.
`default_nettype none
// Summary of operation
// R1 - Twenty-six inputs: eighteen high-side, four low-side, four encoder pins.
// R2 - Inputs 1 to 18 read on when driven to battery positive.
// R3 - Inputs 19 to 22 read on when open, off when grounded.
// R4 - Encoder pins read off when grounded, on when open with pull-up.
// R5 - Debounce time 0 to 32 ms in 4 ms steps, set by step count.
// R6 - Without configuration the debounce time is 16 ms.
// R7 - All inputs are sampled 250 times per second.
// R8 - Off to on sets the input's press latch.
// R9 - On to off sets the input's release latch.
// R10 - Latches stay set; opposite transitions never clear them.
// R11 - Software clears a latch by writing it; it may then set again.
// R12 - Press and release latches of one input may both be set.
// R13 - Inputs 1 to 24 each have a press and a release latch.
// R14 - Encoder-pin inputs have latches that behave like the others.
// R15 - Output-driver sense inputs are plain switch inputs following the driver.
// R16 - State changes after raw differs for the full debounce time; zero passes through.
// R17 - A clear and a matching transition together leave the latch set.
module swdb_top #(
    parameter int NUM_INPUTS = swdb_pkg::SWDB_NUM_INPUTS,
    parameter int SAMPLE_CYCLES = swdb_pkg::SWDB_SAMPLE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_INPUTS-1:0] switch_pin,
    output logic [NUM_INPUTS-1:0] switch_state,
    output logic irq
);
    import swdb_pkg::*;

    typedef struct packed {
        logic [NUM_INPUTS-1:0] raw;
        logic [NUM_INPUTS-1:0] prev;
        logic [NUM_INPUTS-1:0] press_latch;
        logic [NUM_INPUTS-1:0] release_latch;
        logic [NUM_INPUTS-1:0] press_mask;
        logic [NUM_INPUTS-1:0] release_mask;
        logic [SWDB_STEP_W-1:0] steps;
        logic dp_write;
        logic dp_read;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic [NUM_INPUTS-1:0] state_out;
        logic irq;
    } swdb_top_s;

    swdb_top_s st;
    swdb_top_s next_st;
    logic tick;
    logic [NUM_INPUTS-1:0] polarity_on;
    logic [NUM_INPUTS-1:0] debounced;
    logic [SWDB_CNT_W-1:0] limit;
    logic addr_take;
    logic [31:0] wmask;

    // Sample-rate divider at 250 Hz.
    swdb_tick #(
        .DIVIDE(SAMPLE_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick) // R7
    );

    // Each pin level becomes on or off by its group's sense.
    // Driver sense pins sit among the high-side group, so they just follow the pin.
    always_comb begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (i < SWDB_NUM_HIGH_SIDE) begin
                polarity_on[i] = switch_pin[i]; // R2 R15
            end else begin
                polarity_on[i] = switch_pin[i]; // R3 R4
            end
        end
    end

    // Debounce limit in sample ticks: one step of 4 ms is one tick at 250 Hz.
    assign limit = SWDB_CNT_W'(st.steps * SWDB_TICKS_PER_STEP); // R5

    // One filter per input.
    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g++) begin : gen_filter
            swdb_filter #(
                .CNT_W(SWDB_CNT_W)
            ) u_filter (
                .hclk(hclk),
                .hresetn(hresetn),
                .tick(tick),
                .sample(st.raw[g]),
                .limit(limit),
                .state(debounced[g]) // R1 R16
            );
        end
    endgenerate

    assign addr_take = hsel && hready && htrans == SWDB_HTRANS_NONSEQ;

    // Write-one-to-clear mask for the latch registers.
    assign wmask = st.dp_write ? hwdata : 32'h0000_0000;

    // Sampling, edge latches, register access and interrupt.
    always_comb begin
        next_st = st;
        if (tick) begin
            next_st.raw = polarity_on; // R7
        end
        next_st.prev = debounced;
        // Write-one clears first, then new edges set again, so an event wins.
        if (st.dp_write && st.dp_addr == SWDB_OFS_PRESS) begin
            next_st.press_latch = st.press_latch & ~wmask[NUM_INPUTS-1:0]; // R11
        end
        if (st.dp_write && st.dp_addr == SWDB_OFS_RELEASE) begin
            next_st.release_latch = st.release_latch & ~wmask[NUM_INPUTS-1:0]; // R11
        end
        // Only sets here; no path clears a latch except software. Both may stand.
        next_st.press_latch = next_st.press_latch | (debounced & ~st.prev); // R8 R10 R12 R13 R14 R17
        next_st.release_latch = next_st.release_latch | (~debounced & st.prev); // R9 R10 R12 R17
        if (st.dp_write && st.dp_addr == SWDB_OFS_PRESS_MASK) begin
            next_st.press_mask = hwdata[NUM_INPUTS-1:0];
        end
        if (st.dp_write && st.dp_addr == SWDB_OFS_RELEASE_MASK) begin
            next_st.release_mask = hwdata[NUM_INPUTS-1:0];
        end
        if (st.dp_write && st.dp_addr == SWDB_OFS_DEBOUNCE) begin
            // Steps above 8 would exceed 32 ms, so they are clamped.
            // The whole word is compared, so a large value never wraps to a short time.
            if (hwdata > 32'(SWDB_STEP_MAX)) begin
                next_st.steps = SWDB_STEP_MAX; // R5
            end else begin
                next_st.steps = hwdata[SWDB_STEP_W-1:0]; // R5
            end
        end
        // Address phase capture; the slave never inserts wait states.
        next_st.dp_write = addr_take && hwrite;
        next_st.dp_read = addr_take && !hwrite;
        next_st.dp_addr = addr_take ? haddr[7:0] : st.dp_addr;
        // Read data are registered at the address phase so they stand in the data phase.
        next_st.rdata = 32'h0000_0000;
        if (addr_take && !hwrite) begin
            case (haddr[7:0])
                SWDB_OFS_STATE: next_st.rdata[NUM_INPUTS-1:0] = debounced;
                SWDB_OFS_PRESS: next_st.rdata[NUM_INPUTS-1:0] = st.press_latch;
                SWDB_OFS_RELEASE: next_st.rdata[NUM_INPUTS-1:0] = st.release_latch;
                SWDB_OFS_PRESS_MASK: next_st.rdata[NUM_INPUTS-1:0] = st.press_mask;
                SWDB_OFS_RELEASE_MASK: next_st.rdata[NUM_INPUTS-1:0] = st.release_mask;
                SWDB_OFS_DEBOUNCE: next_st.rdata[SWDB_STEP_W-1:0] = st.steps;
                SWDB_OFS_RAW: next_st.rdata[NUM_INPUTS-1:0] = st.raw;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        next_st.state_out = debounced;
        next_st.irq = |((next_st.press_latch & next_st.press_mask)
            | (next_st.release_latch & next_st.release_mask));
    end

    // State register; debounce step resets to the 16 ms default.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.steps <= SWDB_STEP_DEFAULT; // R6
        end else begin
            st <= next_st;
        end
    end

    assign hrdata = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign switch_state = st.state_out;
    assign irq = st.irq;
endmodule
`default_nettype wire

// ==== bench/swdb_top_sva.sv ====
// Assertion checker on the ports of the switch front end.
`default_nettype none
module swdb_top_sva #(
    parameter int NUM_INPUTS = 26,
    parameter int SAMPLE_CYCLES = 10
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NUM_INPUTS-1:0] switch_state,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import swdb_pkg::*;
    logic rd_q, wr_q;
    logic [7:0] a_q;
    logic [NUM_INPUTS-1:0] pm, rm;
    wire logic req = hsel && hready && htrans == SWDB_HTRANS_NONSEQ;
    // Shadow the masks as written, since the irq checks must not trust the design's copy.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q <= 8'h00;
            pm <= '0;
            rm <= '0;
        end else begin
            rd_q <= req && !hwrite;
            wr_q <= req && hwrite;
            if (req) a_q <= haddr[7:0];
            if (wr_q && a_q == SWDB_OFS_PRESS_MASK) pm <= hwdata[NUM_INPUTS-1:0];
            if (wr_q && a_q == SWDB_OFS_RELEASE_MASK) rm <= hwdata[NUM_INPUTS-1:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    chk_upper_zero: assert property (hrdata[31:26] == 6'h0)
        else $error("unused read data bits not zero");
    chk_step_clamp: assert property (rd_q && a_q == SWDB_OFS_DEBOUNCE |-> hrdata <= 32'h8)
        else $error("debounce steps above eight");
    chk_state_read: assert property (rd_q && a_q == SWDB_OFS_STATE
        |-> hrdata[NUM_INPUTS-1:0] == switch_state)
        else $error("state register differs from state output");
    chk_state_pace: assert property ($changed(switch_state) |=> $stable(switch_state) [*8])
        else $error("state changed between sample ticks");
    chk_irq_masked: assert property ((pm == '0 && rm == '0) [*2] |-> !irq)
        else $error("irq with both masks clear");
    chk_irq_cause: assert property ($rose(irq) |-> (pm | rm) != '0)
        else $error("irq rose without any mask bit");
endmodule
bind swdb_top swdb_top_sva #(.NUM_INPUTS(NUM_INPUTS), .SAMPLE_CYCLES(SAMPLE_CYCLES))
    swdb_top_sva_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .switch_state(switch_state), .irq(irq));
`default_nettype wire

// ==== bench/swdb_switches.sv ====
// Model of the switches and encoder pins wired to the inputs.
`default_nettype none
module swdb_switches (
    input wire logic hclk,
    input wire logic [25:0] level,
    output logic [25:0] switch_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contacts settle one cycle after the bench moves them; a high pin means on.
    initial switch_pin = '0;
    always @(posedge hclk) switch_pin <= level;
endmodule
`default_nettype wire

// ==== bench/swdb_top_test.sv ====
// Self-checking testbench for the switch front end.
`default_nettype none
module swdb_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import swdb_pkg::*;
    localparam logic [31:0] ALL = 32'h03FF_FFFF;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q, v, prev, ep, er;
    logic [1:0] htrans = 0;
    logic [25:0] level = 0, switch_pin, switch_state;
    int err_count = 0, total_checks = 0, cyc = 0;
    always #5 hclk = ~hclk;
    swdb_switches swdb_switches_inst (.hclk(hclk), .level(level), .switch_pin(switch_pin));
    swdb_top #(.SAMPLE_CYCLES(10)) swdb_top_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .switch_pin(switch_pin), .switch_state(switch_state), .irq(irq));
    // One single AHB-Lite transfer; the slave sets the pace through hreadyout.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= SWDB_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        @(posedge hclk);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(q, e);
    endtask
    // Inputs that went from off to on between two levels.
    function automatic logic [31:0] rise(input logic [31:0] p, input logic [31:0] n);
        return ~p & n & ALL;
    endfunction
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // The whole run needs under four hundred cycles, so this ceiling only catches a hang.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end
    // Main sequence: reset values, random levels with all-on and all-off corners, latches.
    initial begin
        void'($urandom(70749));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(SWDB_OFS_DEBOUNCE, 32'h4);
        rd(SWDB_OFS_STATE, 32'h0);
        bus(1'b1, SWDB_OFS_DEBOUNCE, 32'h9);
        rd(SWDB_OFS_DEBOUNCE, 32'h8);
        bus(1'b1, SWDB_OFS_DEBOUNCE, 32'h10);
        rd(SWDB_OFS_DEBOUNCE, 32'h8);
        bus(1'b1, SWDB_OFS_DEBOUNCE, 32'h0);
        bus(1'b1, SWDB_OFS_PRESS_MASK, ALL);
        prev = 0;
        ep = 0;
        er = 0;
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? ALL : (k == 3) ? 32'h0 : $urandom & ALL;
            level <= v[25:0];
            ep |= rise(prev, v);
            er |= rise(v, prev);
            prev = v;
            repeat (40) @(posedge hclk);
            rd(SWDB_OFS_STATE, v);
            cmp({6'h0, switch_state}, v);
            rd(SWDB_OFS_RAW, v);
        end
        rd(SWDB_OFS_PRESS, ep);
        rd(SWDB_OFS_RELEASE, er);
        cmp({31'h0, irq}, 32'h1);
        bus(1'b1, SWDB_OFS_PRESS, ALL);
        repeat (3) @(posedge hclk);
        cmp({31'h0, irq}, 32'h0);
        rd(SWDB_OFS_PRESS, 32'h0);
        rd(SWDB_OFS_RELEASE, er);
        // Release events raise the interrupt once their mask opens.
        bus(1'b1, SWDB_OFS_RELEASE_MASK, ALL);
        cmp({31'h0, irq}, {31'h0, er != 32'h0});
        bus(1'b1, SWDB_OFS_RELEASE, ALL);
        cmp({31'h0, irq}, 32'h0);
        rd(SWDB_OFS_RELEASE, 32'h0);
        rd(8'h40, 32'h0);
        bus(1'b1, SWDB_OFS_RAW, ALL);
        rd(SWDB_OFS_RAW, 32'h0);
        level <= 26'h1;
        repeat (40) @(posedge hclk);
        rd(SWDB_OFS_PRESS, 32'h1);
        cmp({31'h0, irq}, 32'h1);
        bus(1'b1, SWDB_OFS_DEBOUNCE, 32'h2);
        level <= 26'h0;
        repeat (5) @(posedge hclk);
        rd(SWDB_OFS_STATE, 32'h1);
        repeat (40) @(posedge hclk);
        rd(SWDB_OFS_STATE, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
